//--- asp_pkg.sv
// Purpose: shared constants and enumerations of the arbitrary-waveform sequence player
// Assumes: rates are counted in units of 10 kHz; the reference clock runs at 250 MHz
// Notes: enumerations follow the documented encodings in declaration order
package asp_pkg;
   // table and field sizes
   localparam int SEG_MAX = 64;
   localparam int SEG_IDX_W = 6;
   localparam int SEG_CNT_W = 7;
   localparam int ADDR_W = 16;
   localparam int LEN_W = 16;
   localparam int REPS_W = 16;
   localparam int MK_W = 4;
   localparam int RATE_W = 16;
   localparam int SAMPLE_W = 32;
   localparam int FIFO_DEPTH = 4;

   // rate figures, as printed, in MHz, and in the 10 kHz count unit
   localparam int RATE_UNIT_KHZ = 10;
   localparam int REF_CLK_MHZ = 250;
   localparam int INT_CLK_MHZ = 200;
   localparam int CUSTOM_DEFAULT_MHZ = 100;
   localparam int CUSTOM_MAX_MHZ = 250;
   localparam logic [RATE_W-1:0] RATE_REF = RATE_W'(REF_CLK_MHZ * 1000 / RATE_UNIT_KHZ);
   localparam logic [RATE_W-1:0] RATE_INT = RATE_W'(INT_CLK_MHZ * 1000 / RATE_UNIT_KHZ);
   localparam logic [RATE_W-1:0] RATE_MAX = RATE_W'(CUSTOM_MAX_MHZ * 1000 / RATE_UNIT_KHZ);
   localparam logic [RATE_W-1:0] RATE_MIN = 16'h0001;
   localparam logic [RATE_W-1:0] RATE_DEFAULT = RATE_W'(CUSTOM_DEFAULT_MHZ * 1000 / RATE_UNIT_KHZ);

   // entry defaults and encodings
   localparam logic [REPS_W-1:0] REPS_DEFAULT = 16'h0001;
   localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
   localparam logic [SEG_CNT_W-1:0] SEG_CNT_ONE = 7'h01;
   localparam logic WORK_SINGLE_FILE = 1'b0;
   localparam logic WORK_SEQUENCE = 1'b1;
   localparam logic GATE_ACTIVE_HIGH = 1'b1;

   typedef enum logic [1:0] {ASP_CLK_SEGMENT, ASP_CLK_HIGHEST, ASP_CLK_CUSTOM} asp_clk_type_t;
   typedef enum logic [1:0] {ASP_TRIG_CONT, ASP_TRIG_SINGLE, ASP_TRIG_SEGMENT,
      ASP_TRIG_GATED} asp_trig_mode_t;
   typedef enum logic [1:0] {ASP_SUB_FREE, ASP_SUB_TRIGGERED, ASP_SUB_RESTART} asp_sub_t;
   typedef enum logic [1:0] {ASP_SRC_KEY, ASP_SRC_BUS, ASP_SRC_EXT, ASP_SRC_INT} asp_src_t;
   typedef enum logic [1:0] {ASP_IDLE, ASP_WAIT, ASP_PLAY, ASP_DONE} asp_state_t;
endpackage

//--- asp_fifo.sv
// Purpose: small first-in first-out buffer for played samples and markers
// Assumes: single clock; clear empties the buffer at once
// Notes: storage is flip-flops; level tells the writer how much room is left
`timescale 1ns/10ps
`default_nettype none
module asp_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);
   localparam logic [$clog2(DEPTH+1)-1:0] LVL_FULL = ($clog2(DEPTH+1))'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [$clog2(DEPTH+1)-1:0] next_level;
   logic push, pop;

   // honest flags straight from the fill level
   assign in_ready = (level != LVL_FULL);
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and level update
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_level = level;
      if (clear) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_level = '0;
      end else begin
         if (push) begin
            next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
         end
         if (pop) begin
            next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;
         end
         if (push && !pop) begin
            next_level = level + 1'b1;
         end else if (pop && !push) begin
            next_level = level - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level <= next_level;
      end
   end

   // storage; contents need no reset since level guards them
   always_ff @(posedge ref_clk) begin
      if (push && !clear) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- asp_rate_gen.sv
// Purpose: sample-rate enable from the reference clock by fractional accumulation
// Assumes: rate and reference are in the same unit; rate never exceeds the reference
// Notes: jitter is one reference cycle; average rate is exact
`timescale 1ns/10ps
`default_nettype none
module asp_rate_gen #(
   parameter int RATE_W = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic [RATE_W-1:0] rate,
   input wire logic [RATE_W-1:0] ref_rate,
   output logic tick
);
   logic [RATE_W-1:0] acc, next_acc;
   logic [RATE_W:0] sum;

   // one tick each time the sum reaches or passes the reference rate
   always_comb begin
      sum = {1'b0, acc} + {1'b0, rate};
      tick = 1'b0;
      next_acc = sum[RATE_W-1:0];
      if (clear) begin
         next_acc = '0;
      end else if (sum >= {1'b0, ref_rate}) begin
         tick = 1'b1;
         next_acc = RATE_W'(sum - {1'b0, ref_rate});
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         acc <= '0;
      end else begin
         acc <= next_acc;
      end
   end
endmodule
`default_nettype wire

//--- asp_player.sv
// Purpose: arbitrary-waveform playback controller, single file or segment sequence
// Assumes: waveform memory answers one cycle after a read; modulator drains out_*
// Notes: configuration comes in as plain levels and one-cycle command pulses
`timescale 1ns/10ps
`default_nettype none
module asp_player #(
   parameter int SAMPLE_W = asp_pkg::SAMPLE_W,
   parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic play_enable,
   input wire logic work_pattern,
   input wire logic [1:0] clock_type,
   input wire logic samp_clk_external,
   input wire logic [asp_pkg::RATE_W-1:0] custom_rate,
   input wire logic [1:0] trig_mode,
   input wire logic [1:0] trig_sub,
   input wire logic [1:0] trig_source,
   input wire logic gate_active_high,
   input wire logic trig_key,
   input wire logic trig_bus,
   input wire logic trig_int,
   input wire logic trig_ext_pin,
   input wire logic [asp_pkg::ADDR_W-1:0] file_base,
   input wire logic [asp_pkg::LEN_W-1:0] file_len,
   input wire logic [asp_pkg::MK_W-1:0] file_markers,
   input wire logic new_seq,
   input wire logic seg_wr,
   input wire logic [asp_pkg::ADDR_W-1:0] seg_wr_base,
   input wire logic [asp_pkg::LEN_W-1:0] seg_wr_len,
   input wire logic [asp_pkg::REPS_W-1:0] seg_wr_reps,
   input wire logic [asp_pkg::MK_W-1:0] marker_enable_set,
   input wire logic [asp_pkg::RATE_W-1:0] seg_wr_rate,
   output logic mem_rd_en,
   output logic [asp_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [SAMPLE_W-1:0] mem_rd_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [SAMPLE_W-1:0] out_sample,
   output logic [asp_pkg::MK_W-1:0] out_markers,
   output logic playing,
   output logic waiting,
   output logic [asp_pkg::SEG_IDX_W-1:0] seg_index,
   output logic [asp_pkg::SEG_CNT_W-1:0] seg_count,
   output logic seg_list_full,
   output logic seg_wr_refused,
   output logic clock_type_refused,
   output logic [asp_pkg::RATE_W-1:0] active_rate
);
   localparam int FW = SAMPLE_W + asp_pkg::MK_W;
   localparam int LW = $clog2(FIFO_DEPTH + 1);
   localparam logic [LW+1:0] ROOM = (LW+2)'(FIFO_DEPTH);

   // segment table, one flip-flop entry per slot
   logic [asp_pkg::ADDR_W-1:0] tbl_base [asp_pkg::SEG_MAX];
   logic [asp_pkg::LEN_W-1:0] tbl_len [asp_pkg::SEG_MAX];
   logic [asp_pkg::REPS_W-1:0] tbl_reps [asp_pkg::SEG_MAX];
   logic [asp_pkg::MK_W-1:0] tbl_mk [asp_pkg::SEG_MAX];
   logic [asp_pkg::RATE_W-1:0] tbl_rate [asp_pkg::SEG_MAX];

   asp_pkg::asp_state_t state, next_state;
   logic [asp_pkg::SEG_CNT_W-1:0] next_seg_count;
   logic [asp_pkg::RATE_W-1:0] max_rate, next_max_rate;
   logic next_seg_wr_refused, new_seq_ok, seg_wr_ok;
   logic [asp_pkg::SEG_IDX_W-1:0] next_seg_index;
   logic [asp_pkg::REPS_W-1:0] rep_cnt, next_rep_cnt;
   logic [asp_pkg::LEN_W-1:0] samp_cnt, next_samp_cnt;
   logic [asp_pkg::ADDR_W-1:0] next_mem_rd_addr;
   logic [asp_pkg::MK_W-1:0] rd_mk, next_rd_mk, data_mk, next_data_mk;
   logic next_mem_rd_en, data_valid, next_data_valid;
   logic [2:0] ext_sync;
   logic flush, step, tick, fifo_in_ready, trig, gate_ok, loaded, seq_mode;
   logic last_samp, last_rep, last_seg, retrig_ok, pass_loops, space;
   logic [LW-1:0] fifo_level;
   logic [asp_pkg::ADDR_W-1:0] cur_base;
   logic [asp_pkg::LEN_W-1:0] cur_len;
   logic [asp_pkg::REPS_W-1:0] cur_reps;
   logic [asp_pkg::MK_W-1:0] cur_mk;
   logic [asp_pkg::RATE_W-1:0] cur_rate, prog_rate;
   asp_pkg::asp_clk_type_t clk_type_eff;
   asp_pkg::asp_trig_mode_t mode;
   asp_pkg::asp_sub_t sub;

   // keep any rate inside the documented programmable span
   function automatic logic [asp_pkg::RATE_W-1:0] clamp_rate(
      input logic [asp_pkg::RATE_W-1:0] r);
      logic [asp_pkg::RATE_W-1:0] c;
      c = r;
      if (r < asp_pkg::RATE_MIN) begin
         c = asp_pkg::RATE_MIN;
      end else if (r > asp_pkg::RATE_MAX) begin
         c = asp_pkg::RATE_MAX;
      end
      return c;
   endfunction

   assign seq_mode = (work_pattern == asp_pkg::WORK_SEQUENCE);
   assign mode = asp_pkg::asp_trig_mode_t'(trig_mode);
   assign sub = asp_pkg::asp_sub_t'(trig_sub);

   // the current entry: the file itself or the indexed table slot
   always_comb begin
      if (seq_mode) begin
         cur_base = tbl_base[seg_index];
         cur_len = tbl_len[seg_index];
         cur_reps = tbl_reps[seg_index];
         cur_mk = tbl_mk[seg_index];
      end else begin
         cur_base = file_base;
         cur_len = file_len;
         cur_reps = asp_pkg::REPS_DEFAULT;
         cur_mk = file_markers;
      end
      if (cur_len == '0) begin
         cur_len = asp_pkg::LEN_ONE;
      end
      if (cur_reps == '0) begin
         cur_reps = asp_pkg::REPS_DEFAULT;
      end
   end

   // rate source; a single file may only run at the programmed rate
   assign clock_type_refused = !seq_mode
      && (asp_pkg::asp_clk_type_t'(clock_type) != asp_pkg::ASP_CLK_CUSTOM);
   assign prog_rate = samp_clk_external ? clamp_rate(custom_rate) : asp_pkg::RATE_INT;
   always_comb begin
      clk_type_eff = asp_pkg::asp_clk_type_t'(clock_type);
      if (!seq_mode || clock_type == 2'h3) begin
         clk_type_eff = asp_pkg::ASP_CLK_CUSTOM;
      end
      cur_rate = tbl_rate[seg_index];
      unique case (clk_type_eff)
         asp_pkg::ASP_CLK_SEGMENT: active_rate = clamp_rate(cur_rate);
         asp_pkg::ASP_CLK_HIGHEST: active_rate = clamp_rate(max_rate);
         asp_pkg::ASP_CLK_CUSTOM: active_rate = prog_rate;
      endcase
   end

   // list commands; a write beyond the last slot is refused
   assign new_seq_ok = new_seq && seq_mode;
   assign seg_list_full = (seg_count == asp_pkg::SEG_CNT_W'(asp_pkg::SEG_MAX));
   assign seg_wr_ok = seg_wr && seq_mode && !seg_list_full && !new_seq_ok;
   always_comb begin
      next_seg_count = seg_count;
      next_max_rate = max_rate;
      next_seg_wr_refused = seg_wr && !seg_wr_ok;
      if (new_seq_ok) begin
         next_seg_count = '0;
         next_max_rate = '0;
      end else if (seg_wr_ok) begin
         next_seg_count = seg_count + asp_pkg::SEG_CNT_ONE;
         if (clamp_rate(seg_wr_rate) > max_rate) begin
            next_max_rate = clamp_rate(seg_wr_rate);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         seg_count <= '0;
         max_rate <= '0;
         seg_wr_refused <= 1'b0;
      end else begin
         seg_count <= next_seg_count;
         max_rate <= next_max_rate;
         seg_wr_refused <= next_seg_wr_refused;
      end
   end

   // one slot per entry, written at the current end of the list
   for (genvar e = 0; e < asp_pkg::SEG_MAX; e++) begin : g_entry
      logic hit;
      assign hit = seg_wr_ok && (seg_count[asp_pkg::SEG_IDX_W-1:0] == asp_pkg::SEG_IDX_W'(e));
      always_ff @(posedge ref_clk or negedge resetn) begin
         if (!resetn) begin
            tbl_base[e] <= '0;
            tbl_len[e] <= '0;
            tbl_reps[e] <= asp_pkg::REPS_DEFAULT;
            tbl_mk[e] <= '0;
            tbl_rate[e] <= asp_pkg::RATE_DEFAULT;
         end else if (hit) begin
            tbl_base[e] <= seg_wr_base;
            tbl_len[e] <= seg_wr_len;
            tbl_reps[e] <= seg_wr_reps;
            tbl_mk[e] <= marker_enable_set;
            tbl_rate[e] <= seg_wr_rate;
         end
      end
   end

   // trigger selection; the pin triggers on a rising edge across the two late stages and gates only once they agree
   always_comb begin
      unique case (asp_pkg::asp_src_t'(trig_source))
         asp_pkg::ASP_SRC_KEY: trig = trig_key;
         asp_pkg::ASP_SRC_BUS: trig = trig_bus;
         asp_pkg::ASP_SRC_EXT: trig = ext_sync[1] && !ext_sync[2];
         asp_pkg::ASP_SRC_INT: trig = trig_int;
      endcase
   end
   assign gate_ok = (mode != asp_pkg::ASP_TRIG_GATED)
      || ((ext_sync[2] == ext_sync[1]) && (ext_sync[2] == gate_active_high));

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ext_sync <= '0;
      end else begin
         ext_sync <= {ext_sync[1:0], trig_ext_pin};
      end
   end

   // position bookkeeping and pacing
   assign loaded = play_enable && (seq_mode ? (seg_count != '0) : (file_len != '0));
   assign last_samp = (samp_cnt == cur_len - asp_pkg::LEN_ONE);
   assign last_rep = (rep_cnt == cur_reps - asp_pkg::REPS_DEFAULT);
   assign last_seg = !seq_mode
      || ({1'b0, seg_index} == seg_count - asp_pkg::SEG_CNT_ONE);
   // two reads can be in flight, so room is judged against both
   assign space = ((LW+2)'(fifo_level) + (LW+2)'(mem_rd_en) + (LW+2)'(data_valid)) < ROOM;
   assign step = (state == asp_pkg::ASP_PLAY) && tick && space && gate_ok;
   assign retrig_ok = (sub == asp_pkg::ASP_SUB_RESTART)
      && (mode == asp_pkg::ASP_TRIG_CONT || mode == asp_pkg::ASP_TRIG_SINGLE);
   assign pass_loops = (mode == asp_pkg::ASP_TRIG_GATED)
      || (mode == asp_pkg::ASP_TRIG_CONT && sub == asp_pkg::ASP_SUB_FREE)
      || (mode != asp_pkg::ASP_TRIG_SEGMENT && sub == asp_pkg::ASP_SUB_RESTART);

   always_comb begin
      next_state = state;
      next_seg_index = seg_index;
      next_rep_cnt = rep_cnt;
      next_samp_cnt = samp_cnt;
      flush = 1'b0;
      if (!loaded) begin
         next_state = asp_pkg::ASP_IDLE;
         next_seg_index = '0;
         next_rep_cnt = '0;
         next_samp_cnt = '0;
         flush = 1'b1;
      end else begin
         unique case (state)
            asp_pkg::ASP_IDLE: begin
               if (mode == asp_pkg::ASP_TRIG_GATED
                  || (mode != asp_pkg::ASP_TRIG_SEGMENT && sub == asp_pkg::ASP_SUB_FREE)) begin
                  next_state = asp_pkg::ASP_PLAY;
               end else begin
                  next_state = asp_pkg::ASP_WAIT;
               end
            end
            asp_pkg::ASP_WAIT: begin
               if (trig) begin
                  next_state = asp_pkg::ASP_PLAY;
               end
            end
            asp_pkg::ASP_PLAY: begin
               if (retrig_ok && trig) begin
                  next_seg_index = '0;
                  next_rep_cnt = '0;
                  next_samp_cnt = '0;
                  flush = 1'b1;
               end else if (step) begin
                  next_samp_cnt = samp_cnt + asp_pkg::LEN_ONE;
                  if (last_samp) begin
                     next_samp_cnt = '0;
                     if (mode == asp_pkg::ASP_TRIG_SEGMENT) begin
                        next_rep_cnt = '0;
                        next_seg_index = last_seg ? '0 : seg_index + 1'b1;
                        next_state = asp_pkg::ASP_WAIT;
                     end else if (!last_rep) begin
                        next_rep_cnt = rep_cnt + asp_pkg::REPS_DEFAULT;
                     end else begin
                        next_rep_cnt = '0;
                        next_seg_index = last_seg ? '0 : seg_index + 1'b1;
                        if (last_seg && !pass_loops) begin
                           next_state = (sub == asp_pkg::ASP_SUB_TRIGGERED)
                              ? asp_pkg::ASP_WAIT : asp_pkg::ASP_DONE;
                        end
                     end
                  end
               end
            end
            asp_pkg::ASP_DONE: next_state = asp_pkg::ASP_DONE;
         endcase
      end
   end

   // read pipeline: address, then data one cycle later with its markers
   always_comb begin
      next_mem_rd_en = step && !flush;
      next_mem_rd_addr = step ? addr_sum(cur_base, samp_cnt) : mem_rd_addr;
      next_rd_mk = step ? cur_mk : rd_mk;
      next_data_valid = mem_rd_en && !flush;
      next_data_mk = rd_mk;
   end

   function automatic logic [asp_pkg::ADDR_W-1:0] addr_sum(
      input logic [asp_pkg::ADDR_W-1:0] b, input logic [asp_pkg::LEN_W-1:0] o);
      return asp_pkg::ADDR_W'(b + o);
   endfunction

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= asp_pkg::ASP_IDLE;
         seg_index <= '0;
         rep_cnt <= '0;
         samp_cnt <= '0;
         mem_rd_en <= 1'b0;
         mem_rd_addr <= '0;
         rd_mk <= '0;
         data_valid <= 1'b0;
         data_mk <= '0;
      end else begin
         state <= next_state;
         seg_index <= next_seg_index;
         rep_cnt <= next_rep_cnt;
         samp_cnt <= next_samp_cnt;
         mem_rd_en <= next_mem_rd_en;
         mem_rd_addr <= next_mem_rd_addr;
         rd_mk <= next_rd_mk;
         data_valid <= next_data_valid;
         data_mk <= next_data_mk;
      end
   end

   assign playing = (state == asp_pkg::ASP_PLAY);
   assign waiting = (state == asp_pkg::ASP_WAIT);

   asp_rate_gen #(
      .RATE_W(asp_pkg::RATE_W)
   ) u_rate (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clear(!playing),
      .rate(active_rate),
      .ref_rate(asp_pkg::RATE_REF),
      .tick(tick)
   );

   // markers ride in the same word as their sample
   asp_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clear(flush),
      .in_valid(data_valid),
      .in_ready(fifo_in_ready),
      .in_data({data_mk, mem_rd_data}),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data({out_markers, out_sample}),
      .level(fifo_level)
   );

   // the room check above keeps fifo_in_ready high whenever data_valid is set
   logic unused_ready;
   assign unused_ready = fifo_in_ready;
endmodule
`default_nettype wire

//--- asp_player_properties.sv
// Purpose: port checks on the sequence player
// Assumes: one clock domain; rates in 10 kHz units
// Notes: bound to every player instance
`timescale 1ns/10ps
`default_nettype none
module asp_player_properties (
   input wire logic ref_clk, resetn, play_enable, work_pattern, samp_clk_external, new_seq,
   input wire logic seg_wr, out_ready, out_valid, playing, seg_list_full, seg_wr_refused,
   input wire logic clock_type_refused,
   input wire logic [1:0] clock_type, trig_sub,
   input wire logic [15:0] custom_rate, active_rate,
   input wire logic [31:0] out_sample,
   input wire logic [6:0] seg_count
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // list bookkeeping
   property p_full; seg_list_full == (seg_count == 7'h40); endproperty
   a_full: assert property (p_full) else $error("full flag off");
   property p_append; seg_wr && work_pattern && !seg_list_full && !new_seq
      |=> seg_count == $past(seg_count) + 7'h01; endproperty
   a_append: assert property (p_append) else $error("append miscounted");
   property p_over; seg_wr && seg_list_full |=> seg_wr_refused; endproperty
   a_over: assert property (p_over) else $error("write past full taken");
   property p_single; seg_wr && !work_pattern |=> seg_wr_refused && $stable(seg_count); endproperty
   a_single: assert property (p_single) else $error("write in file mode taken");
   property p_clear; new_seq && work_pattern |=> seg_count == 7'h00; endproperty
   a_clear: assert property (p_clear) else $error("list not emptied");
   // clock selection is combinational; two cycles of disable leave the player stopped
   property p_ctype; clock_type_refused == (!work_pattern && clock_type != 2'h2); endproperty
   a_ctype: assert property (p_ctype) else $error("clock type refusal wrong");
   property p_int; clock_type == 2'h2 && !samp_clk_external |-> active_rate == 16'h4e20;
   endproperty
   a_int: assert property (p_int) else $error("internal rate wrong");
   property p_prog; clock_type == 2'h2 && samp_clk_external
      && custom_rate inside {[16'h0001:16'h61a8]} |-> active_rate == custom_rate; endproperty
   a_prog: assert property (p_prog) else $error("programmed rate wrong");
   property p_stop; !play_enable ##1 !play_enable |-> !playing; endproperty
   a_stop: assert property (p_stop) else $error("playing while disabled");
   // a stalled word stands unless a flush is due
   property p_hold; out_valid && !out_ready && play_enable && !new_seq && trig_sub != 2'h2
      |=> out_valid && $stable(out_sample); endproperty
   a_hold: assert property (p_hold) else $error("stalled word lost");
   c_play: cover property ($rose(playing));
   c_ref: cover property (seg_wr_refused);
   c_stall: cover property (out_valid && !out_ready);
endmodule
bind asp_player asp_player_properties u_props (.*);
`default_nettype wire

//--- asp_mod_model.sv
// Purpose: modulator side: waveform memory and sample sink
// Assumes: memory answers the cycle after a read
// Notes: stall holds ready low so the buffer fills
`timescale 1ns/10ps
`default_nettype none
module asp_mod_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic stall,
   input wire logic mem_rd_en,
   input wire logic [15:0] mem_rd_addr,
   output var logic [31:0] mem_rd_data,
   output var logic out_ready
);
   initial out_ready = 1'b0;
   // data valid one cycle only, then churns so stale reads show
   always @(posedge ref_clk) begin
      mem_rd_data <= mem_rd_en ? {16'h5a5a, mem_rd_addr} : ~mem_rd_data;
   end
   // ready moves off the sampling edge
   always @(negedge ref_clk) begin
      out_ready <= resetn && !stall;
   end
endmodule
`default_nettype wire

//--- asp_player_tb.sv
// Purpose: self-checking bench of the sequence player
// Assumes: model returns {5a5a, address} per read
// Notes: inputs move on the falling edge
`timescale 1ns/10ps
`default_nettype none
module asp_player_tb;
   logic ref_clk = 1'b0, resetn = 1'b0, stall, play_enable, work_pattern, samp_clk_external;
   logic gate_active_high, trig_key, trig_bus, trig_int, trig_ext_pin, new_seq, seg_wr;
   logic [1:0] clock_type, trig_mode, trig_sub, trig_source;
   logic [15:0] custom_rate, file_base, file_len, seg_wr_base, seg_wr_len, seg_wr_reps;
   logic [15:0] seg_wr_rate, mem_rd_addr, active_rate;
   logic [3:0] file_markers, marker_enable_set, out_markers;
   logic mem_rd_en, out_valid, out_ready, playing, waiting, seg_list_full, seg_wr_refused;
   logic clock_type_refused;
   logic [31:0] mem_rd_data, out_sample;
   logic [5:0] seg_index;
   logic [6:0] seg_count;
   logic [35:0] got[$], exp[$];
   int miscompares = 0, cmp_count = 0, cyc = 0;
   asp_player u_dut (.*);
   asp_mod_model u_model (.*);
   always #2 ref_clk = ~ref_clk;
   // capture handshakes; a hang ends the run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back({out_markers, out_sample});
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("MISMATCH %s exp %h got %h", what, e, g);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask
   task automatic wr(input logic [15:0] b, input logic [15:0] r, input logic [3:0] m);
      @(negedge ref_clk);
      {seg_wr, seg_wr_base, seg_wr_len, seg_wr_reps, marker_enable_set} = {1'b1, b, 16'h2, r, m};
      @(negedge ref_clk);
      seg_wr = 1'b0;
   endtask
   task automatic seg(input logic [15:0] b, input int n, input logic [3:0] m);
      for (int i = 0; i < n; i++) exp.push_back({m, 16'h5a5a, b + 16'(i)});
   endtask
   // far side stalls first for 12 cycles, so the buffer fills, to its limit in runs of four or more words
   task automatic run(input int n);
      stall = 1'b1;
      repeat (12) @(negedge ref_clk);
      stall = 1'b0;
      repeat (n) @(negedge ref_clk);
      chk("count", 36'(exp.size()), 36'(got.size()));
      foreach (exp[i]) if (i < got.size()) chk("word", exp[i], got[i]);
      exp.delete();
      got.delete();
   endtask
   initial begin
      {stall, play_enable, work_pattern, gate_active_high, trig_key, trig_bus, trig_int} = '0;
      {trig_ext_pin, new_seq, seg_wr, seg_wr_base, seg_wr_len, seg_wr_reps, seg_wr_rate} = '0;
      {marker_enable_set, trig_mode, trig_sub, trig_source} = '0;
      {clock_type, samp_clk_external, custom_rate} = {2'h2, 1'b1, 16'h2710};
      {file_base, file_len, file_markers} = {16'h0300, 16'h0003, 4'h9};
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      chk("rate", 36'h2710, 36'(active_rate));
      samp_clk_external = 1'b0;
      @(negedge ref_clk) chk("rate", 36'h4e20, 36'(active_rate));
      clock_type = 2'h0;
      @(negedge ref_clk) chk("ctref", 36'h1, 36'(clock_type_refused));
      wr(16'h0100, 16'h1, 4'h1);
      chk("refused", 36'h1, 36'(seg_wr_refused));
      {clock_type, samp_clk_external, custom_rate, trig_mode} = {2'h2, 1'b1, 16'h61a8, 2'h1};
      play_enable = 1'b1;
      seg(16'h0300, 3, 4'h9);
      run(40);
      {play_enable, work_pattern} = 2'b01;
      pulse(new_seq);
      for (int i = 0; i < 64; i++) wr(16'(i), 16'h1, 4'h0);
      chk("count", 36'h40, 36'(seg_count));
      wr(16'h0000, 16'h1, 4'h0);
      chk("refused", 36'h1, 36'(seg_wr_refused));
      pulse(new_seq);
      chk("count", 36'h0, 36'(seg_count));
      seg_wr_rate = 16'h1388;
      wr(16'h0100, 16'h2, 4'h5);
      seg_wr_rate = 16'h2710;
      wr(16'h0200, 16'h1, 4'hf);
      clock_type = 2'h1;
      @(negedge ref_clk) chk("rate", 36'h2710, 36'(active_rate));
      clock_type = 2'h0;
      @(negedge ref_clk) chk("rate", 36'h1388, 36'(active_rate));
      clock_type = 2'h2;
      {trig_mode, trig_sub, trig_source, play_enable} = {2'h0, 2'h1, 2'h1, 1'b1};
      run(20);
      chk("wait", 36'h1, 36'(waiting));
      pulse(trig_bus);
      seg(16'h0100, 2, 4'h5);
      seg(16'h0100, 2, 4'h5);
      seg(16'h0200, 2, 4'hf);
      run(60);
      play_enable = 1'b0;
      trig_mode = 2'h2;
      @(negedge ref_clk);
      play_enable = 1'b1;
      pulse(trig_bus);
      seg(16'h0100, 2, 4'h5);
      run(40);
      chk("index", 36'h1, 36'(seg_index));
      // free-running continuous play must wrap to the first entry
      {play_enable, trig_mode, trig_sub} = {1'b0, 2'h0, 2'h0};
      @(negedge ref_clk);
      got.delete();
      play_enable = 1'b1;
      repeat (2) begin
         seg(16'h0100, 2, 4'h5);
         seg(16'h0100, 2, 4'h5);
         seg(16'h0200, 2, 4'hf);
      end
      repeat (40) @(negedge ref_clk);
      chk("loops", 36'h1, 36'(got.size() > 12));
      foreach (exp[i]) chk("word", exp[i], got[i]);
      report_and_stop();
   end
endmodule
`default_nettype wire
